// *** design/prog_port.sv ***
// target-side programming port: boot sense, restart detect, clocked link
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic push;
    logic pop;

    // ready is registered from the next count so it leaves a flip-flop
    assign count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    assign out_valid_o = count_reg != '0;
    assign out_data_o = mem[rd_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
            in_ready_o <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready_o <= count_next != (AW + 1)'(DEPTH);
        end
    end
endmodule

// Contract
// - target raises attention output when a breakpoint is hit
// - bytes 80h 24h 80h after reset restart boot firmware
// - both boot sense pins high at startup selects programming mode
// - boot sense pins held low through reset give normal start
// - serial A transmit is zero after reset unless cold boot
// - after cold boot off, drive transmit high and read looped sense pin
// - alternate mode: transmit/receive are port C bits 6 and 7
// - alternate mode: target drives attention pin as link clock
// - target waits for sense handshake or delay before more data
// - target polls host attention line on periodic tick
// - doubler from half crystal only up to about 29.5 MHz
module prog_port
    import prog_port_pkg::*;
#(
    parameter int CLOCK_HZ = CLK_HZ,
    parameter int BIT_LEN = BIT_CYCLES,
    parameter int HSK_DELAY = HSK_DELAY_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic boot_sense_0_i,
    input wire logic boot_sense_1_i,
    input wire logic serial_a_rx_line_i,
    input wire logic cold_boot_en_i,
    input wire logic alt_mode_i,
    input wire logic breakpoint_i,
    input wire logic cable_probe_i,
    input wire logic periodic_tick_i,
    input wire logic handshake_mode_i,
    input wire logic tx_valid_i,
    input wire logic [DATA_W-1:0] tx_data_i,
    output logic tx_ready_o,
    output logic serial_a_tx_line_o,
    output logic status_line_o,
    output logic prog_mode_o,
    output logic restart_boot_o,
    output logic cable_present_o,
    output logic host_request_o,
    output logic [DATA_W-1:0] rx_data_o,
    output logic rx_valid_o,
    output logic doubler_allowed_o
);
    localparam int BW = $clog2(BIT_LEN + 1);
    localparam int DW = $clog2(HSK_DELAY + 1);

    // three-stage input synchronisers
    logic [2:0] s0_sync;
    logic [2:0] s1_sync;
    logic [2:0] rx_sync;
    logic s0_reg;
    logic s1_reg;
    logic rx_reg;
    boot_sense_s sense;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s0_sync <= '0;
            s1_sync <= '0;
            rx_sync <= 3'h7;
            s0_reg <= 1'b0;
            s1_reg <= 1'b0;
            rx_reg <= 1'b1;
        end else begin
            s0_sync <= {s0_sync[1:0], boot_sense_0_i};
            s1_sync <= {s1_sync[1:0], boot_sense_1_i};
            rx_sync <= {rx_sync[1:0], serial_a_rx_line_i};
            if (s0_sync[1] == s0_sync[2]) s0_reg <= s0_sync[2];
            if (s1_sync[1] == s1_sync[2]) s1_reg <= s1_sync[2];
            if (rx_sync[1] == rx_sync[2]) rx_reg <= rx_sync[2];
        end
    end
    assign sense = '{sense_1: s1_reg, sense_0: s0_reg};

    // startup sampling of the boot sense pins
    logic [3:0] settle_reg;
    logic sampled_reg;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_reg <= '0;
            sampled_reg <= 1'b0;
            prog_mode_o <= 1'b0;
        end else if (!sampled_reg) begin
            settle_reg <= settle_reg + 1'b1;
            if (&settle_reg) begin
                sampled_reg <= 1'b1;
                prog_mode_o <= sense.sense_0 && sense.sense_1;
            end
        end
    end

    // 2400 bps receiver for the restart string
    logic [BW-1:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_shift_reg;
    logic rx_busy_reg;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_shift_reg <= '0;
            rx_busy_reg <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= '0;
        end else begin
            rx_valid_o <= 1'b0;
            if (!rx_busy_reg) begin
                if (!rx_reg && !alt_mode_i) begin
                    rx_busy_reg <= 1'b1;
                    rx_cnt_reg <= BW'(BIT_LEN / 2);
                    rx_bit_reg <= '0;
                end
            end else if (rx_cnt_reg != '0) begin
                rx_cnt_reg <= rx_cnt_reg - 1'b1;
            end else begin
                rx_cnt_reg <= BW'(BIT_LEN - 1);
                rx_bit_reg <= rx_bit_reg + 1'b1;
                if (rx_bit_reg == 4'h0 && rx_reg) begin
                    rx_busy_reg <= 1'b0;
                end else if (rx_bit_reg == 4'h9) begin
                    rx_busy_reg <= 1'b0;
                    if (rx_reg) begin
                        rx_valid_o <= 1'b1;
                        rx_data_o <= rx_shift_reg;
                    end
                end else if (rx_bit_reg != 4'h0) begin
                    rx_shift_reg <= {rx_reg, rx_shift_reg[7:1]};
                end
            end
        end
    end

    seq_state_e seq_reg;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seq_reg <= SEQ_IDLE;
            restart_boot_o <= 1'b0;
        end else begin
            restart_boot_o <= 1'b0;
            if (rx_valid_o) begin
                case (seq_reg)
                    SEQ_IDLE: begin
                        seq_reg <= (rx_data_o == RESTART_B0) ? SEQ_GOT1
                                                             : SEQ_IDLE;
                    end
                    SEQ_GOT1: begin
                        if (rx_data_o == RESTART_B1) seq_reg <= SEQ_GOT2;
                        else if (rx_data_o == RESTART_B0) seq_reg <= SEQ_GOT1;
                        else seq_reg <= SEQ_IDLE;
                    end
                    SEQ_GOT2: begin
                        restart_boot_o <= rx_data_o == RESTART_B2;
                        seq_reg <= SEQ_IDLE;
                    end
                    default: seq_reg <= SEQ_IDLE;
                endcase
            end
        end
    end

    // outgoing data buffer for the clocked link
    logic f_valid;
    logic f_ready;
    logic [DATA_W-1:0] f_data;
    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(f_data)
    );

    // target-clocked synchronous link, port C bits as data
    link_state_e link_reg;
    logic [7:0] lk_shift_reg;
    logic [7:0] lk_in_reg;
    logic [2:0] lk_bit_reg;
    logic [3:0] lk_div_reg;
    logic [DW-1:0] lk_wait_reg;
    logic lk_clk_reg;
    logic [PORTC_RX_BIT:PORTC_TX_BIT] portc_reg;
    assign f_ready = alt_mode_i && link_reg == ST_IDLE;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            link_reg <= ST_IDLE;
            lk_shift_reg <= '0;
            lk_in_reg <= '0;
            lk_bit_reg <= '0;
            lk_div_reg <= '0;
            lk_wait_reg <= '0;
            lk_clk_reg <= 1'b0;
            portc_reg <= '0;
        end else begin
            portc_reg[PORTC_RX_BIT] <= rx_reg;
            case (link_reg)
                ST_IDLE: begin
                    lk_clk_reg <= 1'b0;
                    if (f_valid && alt_mode_i) begin
                        lk_shift_reg <= f_data;
                        lk_bit_reg <= '0;
                        lk_div_reg <= '0;
                        portc_reg[PORTC_TX_BIT] <= f_data[0];
                        link_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    lk_div_reg <= lk_div_reg + 1'b1;
                    if (lk_div_reg == 4'(SYNC_CLK_HALF - 1)) begin
                        lk_div_reg <= '0;
                        lk_clk_reg <= !lk_clk_reg;
                        if (lk_clk_reg) begin
                            lk_shift_reg <= {1'b0, lk_shift_reg[7:1]};
                            portc_reg[PORTC_TX_BIT] <= lk_shift_reg[1];
                            lk_bit_reg <= lk_bit_reg + 1'b1;
                            if (&lk_bit_reg) begin
                                link_reg <= ST_WAIT;
                                lk_wait_reg <= DW'(HSK_DELAY);
                            end
                        end else begin
                            lk_in_reg <= {portc_reg[PORTC_RX_BIT],
                                          lk_in_reg[7:1]};
                        end
                    end
                end
                ST_WAIT: begin
                    lk_clk_reg <= 1'b0;
                    if (lk_wait_reg != '0) lk_wait_reg <= lk_wait_reg - 1'b1;
                    if (handshake_mode_i ? sense.sense_0 : lk_wait_reg == '0) begin
                        link_reg <= ST_IDLE;
                    end
                end
                default: link_reg <= ST_IDLE;
            endcase
        end
    end

    // pin drivers and status
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_a_tx_line_o <= 1'b0;
            status_line_o <= 1'b0;
            cable_present_o <= 1'b0;
            host_request_o <= 1'b0;
            doubler_allowed_o <= 1'b0;
        end else begin
            if (alt_mode_i) begin
                serial_a_tx_line_o <= portc_reg[PORTC_TX_BIT];
                status_line_o <= lk_clk_reg;
            end else begin
                serial_a_tx_line_o <= cold_boot_en_i ||
                                      (cable_probe_i && !cold_boot_en_i);
                status_line_o <= breakpoint_i;
            end
            if (cable_probe_i && !cold_boot_en_i && serial_a_tx_line_o) begin
                cable_present_o <= sense.sense_1;
            end
            if (periodic_tick_i) begin
                host_request_o <= sense.sense_1;
            end
            doubler_allowed_o <= CLOCK_HZ <= MAX_DOUBLER_HZ;
        end
    end
endmodule

// *** inc/prog_port_pkg.sv ***
// shared constants and carriers for the programming/debug port
package prog_port_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD = 2400;
    localparam int BIT_CYCLES = (CLK_HZ + BAUD / 2) / BAUD;
    localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam logic [7:0] RESTART_B0 = 8'h80;
    localparam logic [7:0] RESTART_B1 = 8'h24;
    localparam logic [7:0] RESTART_B2 = 8'h80;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_CLK_HALF = 4;
    localparam int HSK_DELAY_CYCLES = 64;
    localparam int MAX_DOUBLER_HZ = 29_500_000;
    localparam int PORTC_TX_BIT = 6;
    localparam int PORTC_RX_BIT = 7;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_GOT1 = 2'b01,
        SEQ_GOT2 = 2'b10
    } seq_state_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_WAIT = 2'b10
    } link_state_e;

    typedef struct packed {
        logic sense_1;
        logic sense_0;
    } boot_sense_s;
endpackage

// *** tb/host_model.sv ***
// host side: reset from dtr, serial sender at BIT_LEN clocks per bit, clocked link receiver
module host_model
    import prog_port_pkg::*;
#(
    parameter int BIT_LEN = 16,
    parameter int GAP = 40,
    parameter int RST_LEN = 10
) (
    input wire logic clock_i,
    input wire logic status_i,
    input wire logic tx_line_i,
    input wire logic alt_i,
    output logic reset_n_o,
    output logic rx_line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] link_q[$];
    logic [7:0] sh = 8'h00;
    int n = 0;
    initial begin
        reset_n_o = 1'b0;
        rx_line_o = 1'b1;
    end
    task automatic pulse_reset(input int len);
        @(posedge clock_i);
        #5 reset_n_o = 1'b0;
        repeat (len) @(posedge clock_i);
        #5 reset_n_o = 1'b1;
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line_o = f[i];
            repeat (BIT_LEN) @(posedge clock_i);
            #5;
        end
    endtask
    task automatic restart(input logic [7:0] mid);
        pulse_reset(RST_LEN);
        repeat (GAP) @(posedge clock_i);
        #5;
        send_byte(RESTART_B0);
        send_byte(mid);
        send_byte(RESTART_B2);
    endtask
    // status read as dsr; in alt mode it clocks the link
    always @(posedge status_i) begin
        if (alt_i) begin
            sh = {tx_line_i, sh[7:1]};
            n++;
            if (n == 8) begin
                link_q.push_back(sh);
                n = 0;
            end
        end
    end
endmodule

// *** tb/prog_port_props.sv ***
// concurrent checks on the programming port pins
module prog_port_props
    import prog_port_pkg::*;
#(
    parameter int CLOCK_HZ = CLK_HZ
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic alt_mode_i,
    input wire logic cold_boot_en_i,
    input wire logic cable_probe_i,
    input wire logic breakpoint_i,
    input wire logic serial_a_tx_line_o,
    input wire logic status_line_o,
    input wire logic restart_boot_o,
    input wire logic rx_valid_o,
    input wire logic [DATA_W-1:0] rx_data_o,
    input wire logic doubler_allowed_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    status_follow_a: assert property (
        $past(reset_n_i) && !alt_mode_i && !$past(alt_mode_i)
        |-> status_line_o == $past(breakpoint_i))
        else $error("status line not following breakpoint");
    tx_zero_a: assert property (
        $past(reset_n_i) && !$past(alt_mode_i) && !$past(cold_boot_en_i)
        && !$past(cable_probe_i) |-> !serial_a_tx_line_o)
        else $error("transmit line not low");
    tx_high_a: assert property (
        $past(reset_n_i) && !$past(alt_mode_i)
        && ($past(cold_boot_en_i) || $past(cable_probe_i))
        |-> serial_a_tx_line_o)
        else $error("transmit line not high while probing");
    restart_once_a: assert property (
        restart_boot_o |=> !restart_boot_o)
        else $error("restart pulse longer than one cycle");
    restart_byte_a: assert property (
        restart_boot_o |-> rx_data_o == RESTART_B2)
        else $error("restart without closing byte");
    rx_pulse_a: assert property (
        rx_valid_o |=> !rx_valid_o)
        else $error("receive valid longer than one cycle");
    doubler_flag_a: assert property (
        $past(reset_n_i)
        |-> doubler_allowed_o == (CLOCK_HZ <= MAX_DOUBLER_HZ))
        else $error("doubler flag wrong");
    link_edge_a: assert property (
        alt_mode_i && $past(alt_mode_i) && $past(alt_mode_i, 2)
        && $changed(serial_a_tx_line_o) |-> !status_line_o)
        else $error("link data changed while clock high");
    link_half_a: assert property (
        alt_mode_i && $rose(status_line_o)
        |-> status_line_o [*4] ##1 !status_line_o)
        else $error("link clock high time wrong");
    restart_c: cover property (restart_boot_o);
    rx_c: cover property (rx_valid_o);
    link_c: cover property (alt_mode_i && $rose(status_line_o));
endmodule

bind prog_port prog_port_props #(.CLOCK_HZ(CLOCK_HZ)) props (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .alt_mode_i(alt_mode_i),
    .cold_boot_en_i(cold_boot_en_i), .cable_probe_i(cable_probe_i),
    .breakpoint_i(breakpoint_i), .serial_a_tx_line_o(serial_a_tx_line_o),
    .status_line_o(status_line_o), .restart_boot_o(restart_boot_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .doubler_allowed_o(doubler_allowed_o));

// *** tb/programming_debug_port_test.sv ***
// self-checking bench for the programming port
module programming_debug_port_test
    import prog_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic reset_n, rx_line, s0 = 1'b0, s1 = 1'b0, loop = 1'b0;
    logic cold = 1'b0, alt = 1'b0, brk = 1'b0, probe = 1'b0;
    logic tick = 1'b0, tx_valid = 1'b0, hsk = 1'b0, ok;
    logic [7:0] tx_data = 8'h00, rx_data;
    logic tx_ready, tx_line, status, prog, restart, cable, req;
    logic rx_valid, dbl;
    logic [7:0] sent[$];
    int mismatches = 0;
    int tests_run = 0;
    int restarts = 0;
    int rx_count = 0;
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) if (restart === 1'b1) restarts++;
    always @(posedge clock_i) if (rx_valid === 1'b1) rx_count++;
    host_model #(.BIT_LEN(16)) host (.clock_i(clock_i), .status_i(status),
        .tx_line_i(tx_line), .alt_i(alt), .reset_n_o(reset_n),
        .rx_line_o(rx_line));
    prog_port #(.BIT_LEN(16), .HSK_DELAY(8)) uut (.clock_i(clock_i),
        .reset_n_i(reset_n), .boot_sense_0_i(s0),
        .boot_sense_1_i(loop ? tx_line : s1), .serial_a_rx_line_i(rx_line),
        .cold_boot_en_i(cold), .alt_mode_i(alt), .breakpoint_i(brk),
        .cable_probe_i(probe), .periodic_tick_i(tick),
        .handshake_mode_i(hsk), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_ready_o(tx_ready),
        .serial_a_tx_line_o(tx_line), .status_line_o(status),
        .prog_mode_o(prog), .restart_boot_o(restart),
        .cable_present_o(cable), .host_request_o(req),
        .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .doubler_allowed_o(dbl));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #5;
    endtask
    task automatic t_prog(input logic v);
        s0 = v;
        s1 = v;
        host.pulse_reset(10);
        step(30);
        check(prog, v);
        check({tx_line, dbl}, 8'h01);
        s0 = 1'b0;
        s1 = 1'b0;
    endtask
    task automatic t_brk;
        brk = 1'b1;
        step(2);
        check(status, 8'h01);
        brk = 1'b0;
        step(2);
        check(status, 8'h00);
    endtask
    task automatic t_restart(input logic [7:0] mid, input logic [7:0] exp);
        restarts = 0;
        rx_count = 0;
        host.restart(mid);
        step(40);
        check(8'(restarts), exp);
        check(8'(rx_count), 8'h03);
        check(rx_data, RESTART_B2);
    endtask
    task automatic t_cable;
        probe = 1'b1;
        loop = 1'b1;
        step(12);
        check({tx_line, cable}, 8'h03);
        loop = 1'b0;
        step(12);
        check(cable, 8'h00);
        probe = 1'b0;
        cold = 1'b1;
        step(2);
        check(tx_line, 8'h01);
        cold = 1'b0;
    endtask
    task automatic t_req(input logic v);
        s1 = v;
        step(6);
        tick = 1'b1;
        step(1);
        tick = 1'b0;
        step(2);
        check(req, v);
        s1 = 1'b0;
    endtask
    task automatic t_alt;
        alt = 1'b1;
        step(4);
        for (int i = 0; i < 8; i++) begin
            tx_data = 8'hA5 ^ 8'(i * 37);
            tx_valid = 1'b1;
            ok = tx_ready;
            step(1);
            if (ok === 1'b1) sent.push_back(tx_data);
        end
        tx_valid = 1'b0;
        check(8'(sent.size() >= 4), 8'h01);
        check(tx_ready, 8'h00);
        step(900);
        check(8'(host.link_q.size()), 8'(sent.size()));
        foreach (sent[i]) check(host.link_q[i], sent[i]);
        alt = 1'b0;
    endtask
    // handshake mode: second byte held until sense 0 goes high
    task automatic t_hsk;
        int base;
        base = host.link_q.size();
        hsk = 1'b1;
        alt = 1'b1;
        for (int i = 0; i < 2; i++) begin
            tx_data = 8'h3C + 8'(i);
            tx_valid = 1'b1;
            step(1);
        end
        tx_valid = 1'b0;
        step(200);
        check(8'(host.link_q.size() - base), 8'h01);
        s0 = 1'b1;
        step(120);
        check(8'(host.link_q.size() - base), 8'h02);
        check(host.link_q[base], 8'h3C);
        check(host.link_q[base + 1], 8'h3D);
        s0 = 1'b0;
        hsk = 1'b0;
        alt = 1'b0;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #3_000_000;
        mismatches++;
        results;
    end
    initial begin
        step(4);
        check({tx_line, status, prog, restart, cable, req, rx_valid,
            tx_ready}, 8'h00);
        host.pulse_reset(5);
        t_prog(1'b1);
        t_prog(1'b0);
        t_brk;
        t_restart(RESTART_B1, 8'h01);
        t_restart(8'h25, 8'h00);
        t_cable;
        t_req(1'b1);
        t_req(1'b0);
        t_alt;
        t_hsk;
        results;
    end
endmodule
